/* File: diag_status_and_gyro_format_tb.sv */
// bench of the diagnostic core driven by the serial host model
// assumes dsg_host on the link and the bound pin checker
`timescale 1ns/100ps
module diag_status_and_gyro_format_tb;
  import dsg_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        sclk, cs_n, mosi, miso, miso_oe, proc_en, reinit;
  logic        st_done = 1'h0, ft_done = 1'h0, ft_fail = 1'h0, fu_done = 1'h0;
  logic        fu_fail = 1'h0, clk_unlock = 1'h0, supply_low = 1'h0, overrun = 1'h0;
  logic        rate_valid = 1'h0;
  logic [2:0]  st_fail = 3'h0, f;
  logic [1:0]  sync_mode = 2'h0;
  logic [3:0]  cmd;
  logic [31:0] x_rate = 32'h0, y_rate = 32'h0, z_rate = 32'h0, kg;
  logic [31:0] r[3];
  logic [15:0] rd, m_stk = 16'h0, m_cnd = 16'h0;
  logic [15:0] q[$];
  int          n_fail = 0, samples_checked = 0, w, n_cmd[4] = '{0, 0, 0, 0};
  always #10 clk = ~clk;
  dsg_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  dsg_diag_core #(.RECOVER_CYCLES(20), .RANGE_SEL(1)) DUT (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .st_done(st_done), .st_fail(st_fail), .ft_done(ft_done), .ft_fail(ft_fail),
    .fu_done(fu_done), .fu_fail(fu_fail), .clk_unlock(clk_unlock),
    .sync_mode(sync_mode), .supply_low(supply_low), .overrun(overrun),
    .rate_valid(rate_valid), .x_rate(x_rate), .y_rate(y_rate), .z_rate(z_rate),
    .cmd_self_test(cmd[0]), .cmd_flash_update(cmd[1]), .cmd_flash_test(cmd[2]),
    .cmd_soft_reset(cmd[3]), .proc_en(proc_en), .reinit(reinit),
    .gyro_scale_factor(kg));
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++) n_cmd[k] += int'(cmd[k] === 1'h1);
  end
  task automatic chkw(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chkw
  task automatic chkn(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chkn
  // a condition that ends still leaves its sticky flag behind
  task automatic setc(input logic [15:0] c);
    m_stk = m_stk | m_cnd;
    m_cnd = c;
  endtask : setc
  task automatic rd_flags(input string what);
    host.xfer(16'h0200, 16, rd);
    host.xfer(16'h0200, 16, rd);
    chkw(what, m_stk | m_cnd, rd);
    chkn("miso enable idle", 32'h0, {31'h0, miso_oe});
    m_stk = m_cnd;
  endtask : rd_flags
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    #500000;
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(75));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    settle();
    host.xfer(16'h82FF, 16, rd);
    rd_flags("flags after reset");
    chkn("scale", 32'h000061A8, kg);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      f = (i == 2) ? 3'h0 : 3'($urandom_range(1, 7));
      @(posedge clk);
      st_done <= 1'h1;
      st_fail <= f;
      @(posedge clk);
      st_done <= 1'h0;
      setc({5'h0, f, 2'h0, |f, 5'h0});
      settle();
      rd_flags("self test flags");
      rd_flags("self test again");
    end
    $display("test self test done");
    @(posedge clk);
    {ft_done, ft_fail, fu_done, fu_fail, overrun} <= 5'h1F;
    @(posedge clk);
    {ft_done, fu_done, overrun} <= 3'h0;
    setc(16'h0046);
    settle();
    rd_flags("flash and overrun");
    @(posedge clk);
    {ft_done, ft_fail, fu_done, fu_fail} <= 4'hA;
    @(posedge clk);
    {ft_done, fu_done} <= 2'h0;
    setc(16'h0002);
    settle();
    rd_flags("flash passed");
    rd_flags("overrun held");
    host.xfer(16'hE81C, 16, rd);
    host.xfer(16'hE880, 16, rd);
    settle();
    m_stk = 16'h0;
    m_cnd = 16'h0;
    for (int k = 0; k < 4; k++) chkn("command pulses", 32'h1, 32'(n_cmd[k]));
    rd_flags("after soft reset");
    $display("test commands done");
    @(posedge clk);
    clk_unlock <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      sync_mode <= 2'(m);
      setc((m == 2) ? 16'h0080 : 16'h0000);
      settle();
      rd_flags("clock error");
    end
    @(posedge clk);
    clk_unlock <= 1'h0;
    host.xfer(16'h0200, 15, rd);
    m_stk = m_stk | 16'h0008;
    rd_flags("framing flag");
    $display("test clock and framing done");
    @(posedge clk);
    supply_low <= 1'h1;
    setc(16'h0010);
    settle();
    settle();
    chkn("processing while low", 32'h0, {31'h0, proc_en});
    @(posedge clk);
    supply_low <= 1'h0;
    for (w = 0; w < 60 && reinit !== 1'h1; w++) begin
      @(posedge clk);
      #1;
    end
    chkn("recovery span", 32'h1, {31'h0, w >= 20 && w < 40});
    setc(16'h0000);
    settle();
    chkn("processing resumed", 32'h1, {31'h0, proc_en});
    rd_flags("low supply flag");
    $display("test supply done");
    foreach (r[a]) begin
      r[a] = $urandom();
      q.push_back(r[a][15:0]);
      q.push_back(r[a][31:16]);
    end
    q.push_back(16'h0000);
    @(posedge clk);
    {x_rate, y_rate, z_rate} <= {r[0], r[1], r[2]};
    rate_valid <= 1'h1;
    @(posedge clk);
    rate_valid <= 1'h0;
    settle();
    for (int a = 0; a < 8; a++) begin
      host.xfer({1'h0, (a < 6) ? 7'(4 + 2 * a) : 7'h20, 8'h00}, 16, rd);
      if (a > 0) chkw("rate word", q.pop_front(), rd);
    end
    $display("test rates done");
    close_out();
  end
endmodule : diag_status_and_gyro_format_tb

/* File: dsg_diag_core.sv */
// diagnostic flag register, gyro rate registers and command decode
// assumes fault and rate inputs come from logic on clk; supply_low and cs_n are pins
`timescale 1ns/100ps
module dsg_diag_core
  import dsg_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC,
  parameter int unsigned RANGE_SEL      = 0
) (
  input  logic        clk,
  input  logic        rst,
  input  logic        sclk,
  input  logic        cs_n,
  input  logic        mosi,
  output logic        miso,
  output logic        miso_oe,
  input  logic        st_done,
  input  logic [2:0]  st_fail,
  input  logic        ft_done,
  input  logic        ft_fail,
  input  logic        fu_done,
  input  logic        fu_fail,
  input  logic        clk_unlock,
  input  logic [1:0]  sync_mode,
  input  logic        supply_low,
  input  logic        overrun,
  input  logic        rate_valid,
  input  logic [31:0] x_rate,
  input  logic [31:0] y_rate,
  input  logic [31:0] z_rate,
  output logic        cmd_self_test,
  output logic        cmd_flash_update,
  output logic        cmd_flash_test,
  output logic        cmd_soft_reset,
  output logic        proc_en,
  output logic        reinit,
  output logic [31:0] gyro_scale_factor
);

  localparam logic [31:0] KG_SEL =
    (RANGE_SEL == 2) ? KG_2000_UDPS :
    (RANGE_SEL == 1) ? KG_500_UDPS  : KG_125_UDPS;

  dsg_link_if lk ();

  dsg_spi_link u_link (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .lk      (lk.link)
  );

  logic        lrst_q;
  logic [2:0]  sh_q [2];
  logic [1:0]  pin_raw;
  logic [1:0]  pin_q;
  logic        cs_last_q;
  logic        end_p;
  logic        tog_last_q;
  logic        loc_rst;

  logic        wr_req;
  logic        rd_req;
  logic [6:0]  acc_addr;
  logic [6:0]  word_addr;
  logic [7:0]  wr_data;
  logic        spi_err;

  logic [15:0] err_q;
  logic [15:0] err_set;
  logic        err_clr;
  logic [15:0] rd_mux;
  logic [15:0] resp_q;

  logic [2:0]  st_fail_q;
  logic        mem_fail_q;
  logic        upd_fail_q;
  logic        ovr_q;

  dsg_pwr_e    pwr_q;
  dsg_pwr_e    pwr_d;
  logic [31:0] rc_q;
  logic        rc_done;

  logic [31:0] x_q;
  logic [31:0] y_q;
  logic [31:0] z_q;

  // soft reset command restarts the fault, flag, supply and rate logic like the pin does
  assign loc_rst = rst | cmd_soft_reset;  // see R14

  // link flops need a reset that also works while sclk stands still
  always_ff @(posedge clk) begin
    lrst_q <= rst;
  end
  assign lk.link_rst = lrst_q;

  // pin synchronisers: a change counts once stages two and three agree
  assign pin_raw = {supply_low, cs_n};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge clk) begin
      if (rst) begin
        sh_q[i]  <= {3{PIN_IDLE[i]}};
        pin_q[i] <= PIN_IDLE[i];
      end else begin
        sh_q[i] <= {sh_q[i][1:0], pin_raw[i]};
        if (sh_q[i][1] == sh_q[i][2]) begin
          pin_q[i] <= sh_q[i][2];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_last_q <= PIN_IDLE[0];
    end else begin
      cs_last_q <= pin_q[0];
    end
  end

  // link words are quiet once select is high, so they are read directly here
  assign end_p = pin_q[0] & ~cs_last_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      tog_last_q <= 1'b0;
    end else if (end_p) begin
      tog_last_q <= lk.fr_tog;
    end
  end

  // a select pulse with no clock edges is ignored entirely
  always_comb begin
    wr_req  = 1'b0;
    rd_req  = 1'b0;
    spi_err = 1'b0;
    if (end_p && (lk.fr_tog != tog_last_q)) begin
      if (lk.bit_cnt != CNT_RESET) begin
        spi_err = 1'b1;  // see R12
      end else if (lk.rx_word[15]) begin
        wr_req = 1'b1;
      end else begin
        rd_req = 1'b1;
      end
    end
  end

  assign acc_addr  = lk.rx_word[14:8];
  assign word_addr = {acc_addr[6:1], 1'b0};
  assign wr_data   = lk.rx_word[7:0];

  // commands are one-cycle strobes; the register itself holds nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_self_test    <= 1'b0;
      cmd_flash_update <= 1'b0;
      cmd_flash_test   <= 1'b0;
      cmd_soft_reset   <= 1'b0;
    end else begin
      cmd_self_test    <= 1'b0;
      cmd_flash_update <= 1'b0;
      cmd_flash_test   <= 1'b0;
      cmd_soft_reset   <= 1'b0;
      if (wr_req && acc_addr == GLOBAL_COMMAND_REGISTER_ADDR) begin  // see R20
        cmd_self_test    <= wr_data[CMD_SELF_TEST];
        cmd_flash_update <= wr_data[CMD_FLASH_UPD];
        cmd_flash_test   <= wr_data[CMD_FLASH_TEST];
        cmd_soft_reset   <= wr_data[CMD_SOFT_RESET];
      end
    end
  end

  // test results stay as fault conditions until the next test ends
  always_ff @(posedge clk) begin
    if (loc_rst) begin
      st_fail_q <= 3'h0;
    end else if (st_done) begin
      st_fail_q <= st_fail;
    end
  end

  always_ff @(posedge clk) begin
    if (loc_rst) begin
      mem_fail_q <= 1'b0;
    end else if (ft_done) begin
      mem_fail_q <= ft_fail;
    end
  end

  always_ff @(posedge clk) begin
    if (loc_rst) begin
      upd_fail_q <= 1'b0;
    end else if (fu_done) begin
      upd_fail_q <= fu_fail;
    end
  end

  // an overrun only goes away with a reset of the device
  always_ff @(posedge clk) begin
    if (loc_rst) begin
      ovr_q <= 1'b0;
    end else if (overrun) begin
      ovr_q <= 1'b1;  // see R14
    end
  end

  // supply watch: data stops while low, restarts after a quiet interval
  assign rc_done = (rc_q == RECOVER_CYCLES - 1);

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      DSG_RUN: begin
        if (pin_q[1]) begin
          pwr_d = DSG_DOWN;
        end
      end
      DSG_DOWN: begin
        if (!pin_q[1]) begin
          pwr_d = DSG_WAIT;
        end
      end
      DSG_WAIT: begin
        if (pin_q[1]) begin
          pwr_d = DSG_DOWN;
        end else if (rc_done) begin
          pwr_d = DSG_RUN;  // see R11
        end
      end
      default: begin
        pwr_d = DSG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (loc_rst) begin
      pwr_q <= DSG_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  always_ff @(posedge clk) begin
    if (loc_rst) begin
      rc_q <= 32'h00000000;
    end else if (pwr_q == DSG_WAIT && !pin_q[1]) begin
      rc_q <= rc_q + 32'h00000001;  // see R11
    end else begin
      rc_q <= 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (loc_rst) begin
      proc_en <= 1'b1;
      reinit  <= 1'b0;
    end else begin
      proc_en <= (pwr_d == DSG_RUN);
      reinit  <= (pwr_q == DSG_WAIT) && (pwr_d == DSG_RUN);
    end
  end

  // present fault conditions; reserved positions stay zero
  always_comb begin
    err_set                  = ERR_RESET;  // see R21
    err_set[BIT_ACCEL_FAIL]  = st_fail_q[2];  // see R5
    err_set[BIT_GYRO2_FAIL]  = st_fail_q[1];  // see R6
    err_set[BIT_GYRO1_FAIL]  = st_fail_q[0];  // see R7
    err_set[BIT_SENSOR_FAIL] = |st_fail_q;  // see R8
    err_set[BIT_CLOCK_ERR]   = clk_unlock && (sync_mode == SYNC_SCALED);  // see R9
    err_set[BIT_MEM_FAIL]    = mem_fail_q;  // see R10
    err_set[BIT_STANDBY]     = (pwr_q != DSG_RUN);  // see R11
    err_set[BIT_SPI_ERR]     = spi_err;  // see R12
    err_set[BIT_FLASH_UPD]   = upd_fail_q;  // see R13
    err_set[BIT_OVERRUN]     = ovr_q;  // see R14
  end

  assign err_clr = rd_req && (word_addr == ERR_FLAGS_ADDR);  // see R2

  // clear first, then set, so a fault in the read cycle survives
  always_ff @(posedge clk) begin
    if (loc_rst) begin
      err_q <= ERR_RESET;  // see R1
    end else if (err_clr) begin
      err_q <= err_set & ERR_USED_MASK;  // see R4 see R22
    end else begin
      err_q <= (err_q | err_set) & ERR_USED_MASK;  // see R3
    end
  end

  // rates freeze while processing is stopped by low supply
  always_ff @(posedge clk) begin
    if (loc_rst) begin
      x_q <= RATE_RESET;
      y_q <= RATE_RESET;
      z_q <= RATE_RESET;
    end else if (rate_valid && pwr_q == DSG_RUN) begin
      x_q <= x_rate;  // see R15 see R16
      y_q <= y_rate;
      z_q <= z_rate;
    end
  end

  // read map; the low word extends the signed high word downward
  always_comb begin
    case (word_addr)
      ERR_FLAGS_ADDR: rd_mux = err_q;
      X_LOW_ADDR:     rd_mux = x_q[15:0];  // see R19
      X_HIGH_ADDR:    rd_mux = x_q[31:16];  // see R18
      Y_LOW_ADDR:     rd_mux = y_q[15:0];
      Y_HIGH_ADDR:    rd_mux = y_q[31:16];
      Z_LOW_ADDR:     rd_mux = z_q[15:0];
      Z_HIGH_ADDR:    rd_mux = z_q[31:16];
      default:        rd_mux = WORD_RESET;
    endcase
  end

  // answer goes out in the next frame, captured before clearing acts
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_q <= WORD_RESET;
    end else if (rd_req) begin
      resp_q <= rd_mux;  // see R2
    end
  end
  assign lk.tx_word = resp_q;

  // fixed per range variant
  always_ff @(posedge clk) begin
    if (rst) begin
      gyro_scale_factor <= KG_125_UDPS;
    end else begin
      gyro_scale_factor <= KG_SEL;  // see R17
    end
  end

endmodule : dsg_diag_core

/* File: dsg_host.sv */
// serial host model that frames words for the diagnostic core
// assumes sclk idles high and both sides sample on its rising edge
`timescale 1ns/100ps
module dsg_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input  logic miso
);
  initial begin
    sclk = 1'h1;
    cs_n = 1'h1;
    mosi = 1'h1;
  end
  // n other than 16 only to provoke the framing flag
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0;
    cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'h0;
      mosi = w[15 - (i % 16)];
      #3;
      rd = {rd[14:0], miso};
      sclk = 1'h1;
      #3;
    end
    cs_n = 1'h1;
    mosi = ~mosi;
    // gap of 10 core clocks so the answer gets loaded
    #200;
  endtask : xfer
endmodule : dsg_host

/* File: dsg_link_if.sv */
// words passed between the serial link logic and the core
// assumes the link side holds its outputs still once the select pin is high
`timescale 1ns/100ps
interface dsg_link_if;
  logic [15:0] rx_word;
  logic [3:0]  bit_cnt;
  logic        fr_tog;
  logic [15:0] tx_word;
  logic        link_rst;

  modport link (output rx_word, output bit_cnt, output fr_tog,
                input tx_word, input link_rst);
  modport core (input rx_word, input bit_cnt, input fr_tog,
                output tx_word, output link_rst);
endinterface : dsg_link_if

/* File: dsg_pkg.sv */
// constants, field layout and state codes of the diagnostic flag and rate block
// assumes a 50 MHz core clock and a host that frames every 16-bit word with its own select pulse
// Operation
// R1: flag register at 0x02, read-only, resets zero
// R2: reading the flag register clears all flags
// R3: flags stay set until the host reads
// R4: persisting fault sets its flag again after clearing
// R5: bit 10 marks accelerometer self test failure
// R6: bit 9 marks second gyroscope self test failure
// R7: bit 8 marks first gyroscope self test failure
// R8: bit 5 marks any sensor self test failure
// R9: bit 7 marks sync clock unlock, scaled mode only
// R10: bit 6 marks failed flash contents check
// R11: bit 4 marks undervoltage; recover after 250 ms
// R12: bit 3 marks frames not multiple of 16 clocks
// R13: bit 2 marks failed flash update
// R14: bit 1 marks overrun; host resets to recover
// R15: three axes, each its own register pair
// R16: high and low words form 32-bit two's complement
// R17: scale 0.00625, 0.025 or 0.1 per LSB
// R18: high word signed, zero rate reads zero
// R19: low word holds 16 extra fraction bits
// R20: command register write-only at 0x68
// R21: reserved flag bits always read zero
// R22: new fault beats a simultaneous clearing read
package dsg_pkg;

  localparam logic [6:0]  ERR_FLAGS_ADDR  = 7'h02;
  localparam logic [6:0]  X_LOW_ADDR      = 7'h04;
  localparam logic [6:0]  X_HIGH_ADDR     = 7'h06;
  localparam logic [6:0]  Y_LOW_ADDR      = 7'h08;
  localparam logic [6:0]  Y_HIGH_ADDR     = 7'h0A;
  localparam logic [6:0]  Z_LOW_ADDR      = 7'h0C;
  localparam logic [6:0]  Z_HIGH_ADDR     = 7'h0E;
  localparam logic [6:0]  GLOBAL_COMMAND_REGISTER_ADDR   = 7'h68;

  localparam logic [15:0] ERR_RESET       = 16'h0000;
  localparam logic [15:0] ERR_USED_MASK   = 16'h07FE;
  localparam int          BIT_ACCEL_FAIL  = 10;
  localparam int          BIT_GYRO2_FAIL  = 9;
  localparam int          BIT_GYRO1_FAIL  = 8;
  localparam int          BIT_CLOCK_ERR   = 7;
  localparam int          BIT_MEM_FAIL    = 6;
  localparam int          BIT_SENSOR_FAIL = 5;
  localparam int          BIT_STANDBY     = 4;
  localparam int          BIT_SPI_ERR     = 3;
  localparam int          BIT_FLASH_UPD   = 2;
  localparam int          BIT_OVERRUN     = 1;

  localparam int          CMD_SELF_TEST   = 2;
  localparam int          CMD_FLASH_UPD   = 3;
  localparam int          CMD_FLASH_TEST  = 4;
  localparam int          CMD_SOFT_RESET  = 7;

  localparam logic [1:0]  SYNC_SCALED     = 2'h2;
  localparam logic [1:0]  PIN_IDLE        = 2'h1;
  localparam logic [3:0]  CNT_RESET       = 4'h0;
  localparam logic [15:0] WORD_RESET      = 16'h0000;
  localparam logic [31:0] RATE_RESET      = 32'h00000000;

  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned RECOVER_MS      = 250;
  localparam int unsigned RECOVER_CYC     = CLK_HZ / 1000 * RECOVER_MS;

  // scale in micro degrees per second per LSB of the high word
  localparam logic [31:0] KG_125_UDPS     = 32'h0000186A;
  localparam logic [31:0] KG_500_UDPS     = 32'h000061A8;
  localparam logic [31:0] KG_2000_UDPS    = 32'h000186A0;

  typedef enum logic [2:0] {
    DSG_RUN  = 3'b001,
    DSG_DOWN = 3'b010,
    DSG_WAIT = 3'b100
  } dsg_pwr_e;

endpackage : dsg_pkg

/* File: dsg_properties.sv */
// pin checker of the diagnostic core: commands, supply recovery, scale
// assumes it is bound into dsg_diag_core and sees only its ports
`timescale 1ns/100ps
module dsg_properties
  import dsg_pkg::*;
#(
  parameter int unsigned RECOVER_CYCLES = RECOVER_CYC,
  parameter int unsigned RANGE_SEL      = 0
) (
  input logic        clk,
  input logic        rst,
  input logic        cs_n,
  input logic        miso_oe,
  input logic        supply_low,
  input logic        cmd_self_test,
  input logic        cmd_flash_update,
  input logic        cmd_flash_test,
  input logic        cmd_soft_reset,
  input logic        proc_en,
  input logic        reinit,
  input logic [31:0] gyro_scale_factor
);
  logic [31:0] good_q;
  logic [31:0] kg_exp;
  logic        any_cmd;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // counted at the pin, so it runs ahead of the core's synchronizer
  always_ff @(posedge clk) begin
    if (rst || supply_low) begin
      good_q <= 32'h0;
    end else if (good_q != 32'hFFFFFFFF) begin
      good_q <= good_q + 32'h1;
    end
  end
  assign kg_exp = (RANGE_SEL == 2) ? 32'h000186A0 :
                  (RANGE_SEL == 1) ? 32'h000061A8 : 32'h0000186A;
  assign any_cmd = cmd_flash_update || cmd_flash_test || cmd_soft_reset;
  sequence s_low_held;
    supply_low [*6];
  endsequence
  sequence s_reinit_done;
    reinit ##1 (!reinit && proc_en);
  endsequence
  low_stops_proc_a: assert property (s_low_held |-> !proc_en)
    else $error("processing runs on low supply");
  reinit_single_a: assert property (reinit |-> s_reinit_done)
    else $error("reinit not a single pulse into processing");
  recover_wait_a: assert property (reinit |-> good_q >= RECOVER_CYCLES)
    else $error("recovery ended too early");
  recover_bound_a: assert property (!proc_en |-> good_q <= RECOVER_CYCLES + 10)
    else $error("recovery ended too late");
  proc_rise_a: assert property ($rose(proc_en) |-> reinit || $past(reinit))
    else $error("processing resumed without reinit");
  st_pulse_a: assert property (cmd_self_test |=> !cmd_self_test)
    else $error("self test command longer than a cycle");
  cmd_pulse_a: assert property (any_cmd |=> !any_cmd)
    else $error("command longer than a cycle");
  cmd_after_frame_a: assert property ((any_cmd || cmd_self_test) |->
    $past(cs_n) && $past(cs_n, 3)) else $error("command while selected");
  scale_const_a: assert property (!$past(rst) |-> gyro_scale_factor == kg_exp)
    else $error("scale factor wrong");
  // the pin is driven exactly while the host selects the device
  oe_follows_sel_a: assert property (miso_oe == !cs_n)
    else $error("miso enable does not follow select");
endmodule : dsg_properties
bind dsg_diag_core dsg_properties #(
  .RECOVER_CYCLES(RECOVER_CYCLES), .RANGE_SEL(RANGE_SEL)
) u_props (.clk(clk), .rst(rst), .cs_n(cs_n), .miso_oe(miso_oe), .supply_low(supply_low),
  .cmd_self_test(cmd_self_test), .cmd_flash_update(cmd_flash_update),
  .cmd_flash_test(cmd_flash_test), .cmd_soft_reset(cmd_soft_reset),
  .proc_en(proc_en), .reinit(reinit), .gyro_scale_factor(gyro_scale_factor));

/* File: dsg_spi_link.sv */
// serial shifter clocked by the host serial clock
// assumes sclk idles high, host samples miso and drives mosi for rising edges
`timescale 1ns/100ps
module dsg_spi_link
  import dsg_pkg::*;
(
  input  logic      sclk,
  input  logic      cs_n,
  input  logic      mosi,
  output logic      miso,
  output logic      miso_oe,
  dsg_link_if.link  lk
);

  logic        first_q;
  logic [15:0] rx_q;
  logic [3:0]  cnt_q;
  logic        tog_q;

  // sclk stops between frames, so frame start is caught by async set
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    rx_q <= {rx_q[14:0], mosi};
  end

  // count kept after the frame so the core can judge its length
  always_ff @(posedge sclk or posedge lk.link_rst) begin
    if (lk.link_rst) begin
      cnt_q <= CNT_RESET;
      tog_q <= 1'b0;
    end else begin
      cnt_q <= first_q ? 4'h1 : cnt_q + 4'h1;
      if (first_q) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // tx word is still in the core domain, held across the frame
  assign miso    = lk.tx_word[first_q ? 4'hF : 4'hF - cnt_q];
  assign miso_oe = ~cs_n;

  assign lk.rx_word = rx_q;
  assign lk.bit_cnt = cnt_q;
  assign lk.fr_tog  = tog_q;
endmodule : dsg_spi_link
